// File: hpbp_pkg.sv
// Function
// R1: width pin low selects 8-bit, high 16-bit
// R2: latch strobe level at reset picks strobe style
// R3: data-strobe style never multiplexes address and data
// R4: latch strobe edge in operation selects multiplexed
// R5: host opens access with address and chip select
// R6: read while read strobe low, write while low
// R7: host holds latch strobe high for separate buses; the code holds it at its strap level, so low in data-strobe style
// R8: host leaves recovery gap between back-to-back accesses
// R9: write address captured at write strobe fall
// R10: all outputs high impedance while reset held
// R11: multiplexed address captured by latch strobe pulse
// R12: write data at cycle end, read drive gated
package hpbp_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   // pins seen by the device synchroniser: data, addr, cs, rd, wr, ale, width
   localparam int DEV_SYNC_W = DATA_W + ADDR_W + 5;
   localparam int CLK_MHZ = 25;
   localparam int RECOV_NS = 120;
   localparam int ADDR_SETUP_NS = 15;
   localparam int RD_PULSE_NS = 60;
   localparam int WR_PULSE_NS = 40;
   localparam logic [3:0] RECOV_CYC = 4'((RECOV_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] ADDR_SETUP_CYC = 4'((ADDR_SETUP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] RD_PULSE_CYC = 4'((RD_PULSE_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] WR_PULSE_CYC = 4'((WR_PULSE_NS * CLK_MHZ + 999) / 1000);
   // strobe kept long enough for both synchronisers and the read round trip
   localparam logic [3:0] STROBE_CYC = 4'h8;
   localparam logic [3:0] ALE_CYC = 4'h2;
   localparam logic [1:0] STRAP_WAIT = 2'h2;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
   typedef enum logic [2:0] {
      HS_IDLE, HS_ALE_HI, HS_ALE_LO, HS_SETUP, HS_STROBE, HS_HOLD, HS_RECOV
   } hpbp_state_t;
endpackage : hpbp_pkg

// File: hpbp_if.sv
`timescale 1ns/100ps
interface hpbp_if;
   logic                          cs_n;
   logic                          rd_n;
   logic                          wr_n;
   logic                          ale;
   logic                          bus_width_select;
   logic [hpbp_pkg::ADDR_W-1:0]   addr;
   logic [hpbp_pkg::DATA_W-1:0]   host_dout;
   logic                          host_doe;
   logic [hpbp_pkg::DATA_W-1:0]   dev_dout;
   logic                          dev_doe;
   logic [hpbp_pkg::DATA_W-1:0]   data_lvl;
   // undriven lines read high, as with bus pull-ups
   assign data_lvl = dev_doe  ? dev_dout  :
                     host_doe ? host_dout : '1;
   modport dev  (input cs_n, rd_n, wr_n, ale, bus_width_select, addr, data_lvl,
                 output dev_dout, dev_doe);
   modport host (output cs_n, rd_n, wr_n, ale, bus_width_select, addr, host_dout,
                 host_doe, input data_lvl);
endinterface : hpbp_if

// File: hpbp_dev_end.sv
`timescale 1ns/100ps
module hpbp_dev_end (
   // clock and reset
   input  wire logic                        core_clk_i,
   input  wire logic                        rst_n_i,
   // processor port
   hpbp_if.dev                              bus,
   // register side
   output logic [hpbp_pkg::ADDR_W-1:0]      reg_addr_o,
   output logic [hpbp_pkg::DATA_W-1:0]      reg_wdata_o,
   output logic                             reg_wr_o,
   output logic                             reg_rd_o,
   output logic                             reg_wide_o,
   input  wire logic [hpbp_pkg::DATA_W-1:0] reg_rdata_i,
   // mode status
   output logic                             rw_style_o,
   output logic                             mux_mode_o
);
   logic [hpbp_pkg::DEV_SYNC_W-1:0] meta_ff, sync_ff, nxt_meta;
   logic [1:0]                      strap_cnt_ff, nxt_strap_cnt;
   logic                            strap_done_ff, nxt_strap_done;
   logic                            rw_style_ff, nxt_rw_style;
   logic                            mux_ff, nxt_mux;
   logic                            ale_prev_ff, nxt_ale_prev;
   logic                            rd_prev_ff, nxt_rd_prev;
   logic                            wr_prev_ff, nxt_wr_prev;
   logic                            wide_ff, nxt_wide;
   logic [hpbp_pkg::ADDR_W-1:0]     addr_ff, nxt_addr;
   logic [hpbp_pkg::DATA_W-1:0]     wdata_ff, nxt_wdata;
   logic [hpbp_pkg::DATA_W-1:0]     dout_ff, nxt_dout;
   logic                            doe_ff, nxt_doe;
   logic                            wr_pulse_ff, nxt_wr_pulse;
   logic                            rd_pulse_ff, nxt_rd_pulse;
   logic [hpbp_pkg::DATA_W-1:0]     s_data;
   logic [hpbp_pkg::ADDR_W-1:0]     s_addr;
   logic                            s_cs_n, s_rd_n, s_wr_n, s_ale, s_width;
   logic                            rd_act, wr_act;

   function automatic logic [hpbp_pkg::DATA_W-1:0] fit_width(
      input logic                        wide,
      input logic [hpbp_pkg::DATA_W-1:0] val);
      fit_width = wide ? val : {hpbp_pkg::BYTE_ZERO, val[hpbp_pkg::BYTE_W-1:0]};
   endfunction : fit_width

   assign {s_width, s_ale, s_wr_n, s_rd_n, s_cs_n, s_addr, s_data} = sync_ff;

   // every pin is asynchronous to core_clk_i
   always_comb begin
      nxt_meta = {bus.bus_width_select, bus.ale, bus.wr_n, bus.rd_n, bus.cs_n,
                  bus.addr, bus.data_lvl};
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= meta_ff;
      end
   end

   always_comb begin
      nxt_strap_cnt  = strap_cnt_ff;
      nxt_strap_done = strap_done_ff;
      nxt_rw_style   = rw_style_ff;
      // wait out the synchroniser so the strap level is the one held at reset
      if (!strap_done_ff) begin
         if (strap_cnt_ff == hpbp_pkg::STRAP_WAIT) begin
            nxt_rw_style   = s_ale;                                     // [R2]
            nxt_strap_done = 1'b1;
         end else begin
            nxt_strap_cnt = strap_cnt_ff + 2'h1;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         strap_cnt_ff  <= 2'h0;
         strap_done_ff <= 1'b0;
         rw_style_ff   <= 1'b0;
      end else begin
         strap_cnt_ff  <= nxt_strap_cnt;
         strap_done_ff <= nxt_strap_done;
         rw_style_ff   <= nxt_rw_style;
      end
   end

   // in data-strobe style rd_n carries the direction (high = read), wr_n the strobe
   always_comb begin
      if (rw_style_ff) begin
         rd_act = strap_done_ff && !s_cs_n && !s_rd_n;                 // [R6]
         wr_act = strap_done_ff && !s_cs_n && !s_wr_n;                 // [R6]
      end else begin
         rd_act = strap_done_ff && !s_cs_n && !s_wr_n && s_rd_n;
         wr_act = strap_done_ff && !s_cs_n && !s_wr_n && !s_rd_n;
      end
   end

   always_comb begin
      nxt_ale_prev = s_ale;
      nxt_rd_prev  = rd_act;
      nxt_wr_prev  = wr_act;
      nxt_wide     = s_width;                                           // [R1]
      // sticky: once multiplexed, only reset returns to separate buses
      nxt_mux = mux_ff || (strap_done_ff && rw_style_ff && (s_ale != ale_prev_ff)); // [R4] [R3]
      nxt_addr = addr_ff;
      if (nxt_mux && ale_prev_ff && !s_ale) begin
         nxt_addr = s_data[hpbp_pkg::ADDR_W-1:0];                       // [R11]
      end else if (!nxt_mux && wr_act && !wr_prev_ff) begin
         nxt_addr = s_addr;                                             // [R9]
      end else if (!nxt_mux && rd_act && !rd_prev_ff) begin
         nxt_addr = s_addr;
      end
      nxt_wdata = wdata_ff;
      if (wr_act) begin
         nxt_wdata = fit_width(wide_ff, s_data);                        // [R1]
      end
      // last sample taken while strobe and select were both still low
      nxt_wr_pulse = wr_prev_ff && !wr_act;                             // [R12]
      nxt_rd_pulse = rd_act && !rd_prev_ff;                             // [R6]
      // drive lags the strobe by the synchroniser; float takes one cycle
      nxt_doe  = rd_act;                                                // [R12]
      nxt_dout = rd_act ? fit_width(wide_ff, reg_rdata_i) : hpbp_pkg::DATA_RST;
   end

   // reset clears the enable, so the data lines float while reset is held
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mux_ff      <= 1'b0;
         ale_prev_ff <= 1'b0;
         rd_prev_ff  <= 1'b0;
         wr_prev_ff  <= 1'b0;
         wide_ff     <= 1'b0;
         addr_ff     <= hpbp_pkg::ADDR_RST;
         wdata_ff    <= hpbp_pkg::DATA_RST;
         wr_pulse_ff <= 1'b0;
         rd_pulse_ff <= 1'b0;
         doe_ff      <= 1'b0;                                           // [R10]
         dout_ff     <= hpbp_pkg::DATA_RST;
      end else begin
         mux_ff      <= nxt_mux;
         ale_prev_ff <= nxt_ale_prev;
         rd_prev_ff  <= nxt_rd_prev;
         wr_prev_ff  <= nxt_wr_prev;
         wide_ff     <= nxt_wide;
         addr_ff     <= nxt_addr;
         wdata_ff    <= nxt_wdata;
         wr_pulse_ff <= nxt_wr_pulse;
         rd_pulse_ff <= nxt_rd_pulse;
         doe_ff      <= nxt_doe;
         dout_ff     <= nxt_dout;
      end
   end

   assign bus.dev_dout = dout_ff;
   assign bus.dev_doe  = doe_ff;
   assign reg_addr_o   = addr_ff;
   assign reg_wdata_o  = wdata_ff;
   assign reg_wr_o     = wr_pulse_ff;
   assign reg_rd_o     = rd_pulse_ff;
   assign reg_wide_o   = wide_ff;
   assign rw_style_o   = rw_style_ff;
   assign mux_mode_o   = mux_ff;
endmodule : hpbp_dev_end

// File: hpbp_host_end.sv
`timescale 1ns/100ps
module hpbp_host_end #(
   parameter bit RW_STYLE = 1'b1,
   parameter bit MUX_MODE = 1'b0,
   parameter bit WIDE     = 1'b1
) (
   // clock and reset
   input  wire logic                        core_clk_i,
   input  wire logic                        rst_n_i,
   // processor port
   hpbp_if.host                             bus,
   // request side
   input  wire logic                        req_i,
   input  wire logic                        req_wr_i,
   input  wire logic [hpbp_pkg::ADDR_W-1:0] req_addr_i,
   input  wire logic [hpbp_pkg::DATA_W-1:0] req_wdata_i,
   output logic                             busy_o,
   output logic                             done_o,
   output logic [hpbp_pkg::DATA_W-1:0]      rdata_o
);
   localparam bit USE_MUX = RW_STYLE && MUX_MODE;

   hpbp_pkg::hpbp_state_t       state_ff, nxt_state;
   logic [3:0]                  cnt_ff, nxt_cnt;
   logic                        cs_n_ff, nxt_cs_n;
   logic                        rd_n_ff, nxt_rd_n;
   logic                        wr_n_ff, nxt_wr_n;
   logic                        ale_ff, nxt_ale;
   logic [hpbp_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
   logic [hpbp_pkg::DATA_W-1:0] dout_ff, nxt_dout;
   logic                        doe_ff, nxt_doe;
   logic                        op_wr_ff, nxt_op_wr;
   logic [hpbp_pkg::DATA_W-1:0] wdata_ff, nxt_wdata;
   logic [hpbp_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
   logic                        done_ff, nxt_done;
   logic                        busy_ff, nxt_busy;
   logic [hpbp_pkg::DATA_W-1:0] meta_ff, sync_ff;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_ff <= hpbp_pkg::DATA_RST;
         sync_ff <= hpbp_pkg::DATA_RST;
      end else begin
         meta_ff <= bus.data_lvl;
         sync_ff <= meta_ff;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff + 4'h1;
      nxt_cs_n  = cs_n_ff;
      nxt_rd_n  = rd_n_ff;
      nxt_wr_n  = wr_n_ff;
      nxt_ale   = ale_ff;
      nxt_addr  = addr_ff;
      nxt_dout  = dout_ff;
      nxt_doe   = doe_ff;
      nxt_op_wr = op_wr_ff;
      nxt_wdata = wdata_ff;
      nxt_rdata = rdata_ff;
      nxt_done  = 1'b0;
      unique case (state_ff)
         hpbp_pkg::HS_IDLE: begin
            nxt_cnt = 4'h0;
            if (req_i) begin
               nxt_op_wr = req_wr_i;
               nxt_wdata = req_wdata_i;
               nxt_addr  = req_addr_i;                                  // [R5]
               if (USE_MUX) begin
                  nxt_state = hpbp_pkg::HS_ALE_HI;
                  nxt_ale   = 1'b1;
                  nxt_dout  = {hpbp_pkg::BYTE_ZERO, req_addr_i};
                  nxt_doe   = 1'b1;
               end else begin
                  nxt_state = hpbp_pkg::HS_SETUP;
                  nxt_cs_n  = 1'b0;                                     // [R5]
                  nxt_rd_n  = RW_STYLE | !req_wr_i;
                  nxt_dout  = req_wdata_i;
                  nxt_doe   = req_wr_i;
               end
            end
         end
         hpbp_pkg::HS_ALE_HI: begin
            if (cnt_ff == hpbp_pkg::ALE_CYC - 4'h1) begin
               nxt_state = hpbp_pkg::HS_ALE_LO;
               nxt_ale   = 1'b0;
            end
         end
         // address stays on the lines one cycle past the latch strobe fall
         hpbp_pkg::HS_ALE_LO: begin
            nxt_state = hpbp_pkg::HS_SETUP;
            nxt_cnt   = 4'h0;
            nxt_cs_n  = 1'b0;                                           // [R5]
            nxt_dout  = wdata_ff;
            nxt_doe   = op_wr_ff;
         end
         hpbp_pkg::HS_SETUP: begin
            if (cnt_ff >= hpbp_pkg::ADDR_SETUP_CYC - 4'h1) begin
               nxt_state = hpbp_pkg::HS_STROBE;
               nxt_cnt   = 4'h0;
               if (RW_STYLE) begin
                  nxt_rd_n = op_wr_ff;                                  // [R6]
                  nxt_wr_n = !op_wr_ff;                                 // [R6]
               end else begin
                  nxt_wr_n = 1'b0;
               end
            end
         end
         hpbp_pkg::HS_STROBE: begin
            if (cnt_ff == hpbp_pkg::STROBE_CYC - 4'h1) begin
               nxt_state = hpbp_pkg::HS_HOLD;
               nxt_wr_n  = 1'b1;
               nxt_rd_n  = RW_STYLE | !op_wr_ff;
               nxt_rdata = op_wr_ff ? rdata_ff : sync_ff;
            end
         end
         // write data held one cycle after the strobe rises
         hpbp_pkg::HS_HOLD: begin
            nxt_state = hpbp_pkg::HS_RECOV;
            nxt_cnt   = 4'h0;
            nxt_cs_n  = 1'b1;
            nxt_rd_n  = 1'b1;
            nxt_doe   = 1'b0;
            nxt_done  = 1'b1;
         end
         hpbp_pkg::HS_RECOV: begin
            if (cnt_ff >= hpbp_pkg::RECOV_CYC - 4'h1) begin
               nxt_state = hpbp_pkg::HS_IDLE;                           // [R8]
            end
         end
      endcase
      nxt_busy = (nxt_state != hpbp_pkg::HS_IDLE);
   end

   // latch strobe constant at the strap level keeps buses separate
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= hpbp_pkg::HS_IDLE;
         cnt_ff   <= 4'h0;
         cs_n_ff  <= 1'b1;
         rd_n_ff  <= 1'b1;
         wr_n_ff  <= 1'b1;
         ale_ff   <= RW_STYLE;                                          // [R2] [R7]
         addr_ff  <= hpbp_pkg::ADDR_RST;
         dout_ff  <= hpbp_pkg::DATA_RST;
         doe_ff   <= 1'b0;
         op_wr_ff <= 1'b0;
         wdata_ff <= hpbp_pkg::DATA_RST;
         rdata_ff <= hpbp_pkg::DATA_RST;
         done_ff  <= 1'b0;
         busy_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         cs_n_ff  <= nxt_cs_n;
         rd_n_ff  <= nxt_rd_n;
         wr_n_ff  <= nxt_wr_n;
         ale_ff   <= nxt_ale;
         addr_ff  <= nxt_addr;
         dout_ff  <= nxt_dout;
         doe_ff   <= nxt_doe;
         op_wr_ff <= nxt_op_wr;
         wdata_ff <= nxt_wdata;
         rdata_ff <= nxt_rdata;
         done_ff  <= nxt_done;
         busy_ff  <= nxt_busy;
      end
   end

   assign bus.cs_n             = cs_n_ff;
   assign bus.rd_n             = rd_n_ff;
   assign bus.wr_n             = wr_n_ff;
   assign bus.ale              = ale_ff;
   assign bus.bus_width_select = WIDE;                                  // [R1]
   assign bus.addr             = addr_ff;
   assign bus.host_dout        = dout_ff;
   assign bus.host_doe         = doe_ff;
   assign busy_o               = busy_ff;
   assign done_o               = done_ff;
   assign rdata_o              = rdata_ff;
endmodule : hpbp_host_end

// File: hpbp_bus_properties.sv
`timescale 1ns/100ps
module hpbp_bus_properties (
   // clock and reset
   input wire logic                      core_clk_i,
   input wire logic                      rst_n_i,
   // watched lines
   input wire logic                      cs_n,
   input wire logic                      rd_n,
   input wire logic                      wr_n,
   input wire logic                      ale,
   input wire logic [hpbp_pkg::ADDR_W-1:0] addr,
   input wire logic                      host_doe,
   input wire logic                      dev_doe
);
   logic rd_act;
   assign rd_act = !rd_n && !cs_n;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   float_at_release_a: assert property ($rose(rst_n_i) |-> !dev_doe)
      else $error("device drives data at reset release");
   read_drive_gated_a: assert property (dev_doe |-> $past(rd_act, 1) || $past(rd_act, 2)
      || $past(rd_act, 3) || $past(rd_act, 4))
      else $error("device drives data outside a read");
   read_answer_a: assert property ($fell(rd_n) && !cs_n |-> ##[1:4] dev_doe)
      else $error("device did not answer a read");
   no_bus_fight_a: assert property (!(dev_doe && host_doe))
      else $error("both ends drive the data lines");
   demux_ale_high_a: assert property (ale)
      else $error("latch strobe left high level on separate buses");
   strobe_gap_a: assert property ($rose(rd_n && wr_n) |-> (rd_n && wr_n) [*3])
      else $error("recovery gap too short");
   access_opens_a: assert property ($fell(rd_n && wr_n) |-> !cs_n && $stable(addr))
      else $error("strobe without chip select and steady address");
   read_width_a: assert property ($fell(rd_n) |-> !rd_n [*6])
      else $error("read strobe too short");
   write_data_held_a: assert property (!wr_n && !cs_n |-> host_doe)
      else $error("write data not driven under strobe");
   write_end_order_a: assert property ($rose(wr_n) |-> !cs_n && host_doe ##1 cs_n)
      else $error("write cycle did not close in order");
endmodule : hpbp_bus_properties

// File: tb_host_processor_bus_port.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
   $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_host_processor_bus_port;
   // pair 0 rd/wr separate 16-bit, pair 1 rd/wr multiplexed 8-bit, pair 2 data-strobe 16-bit
   localparam bit [2:0] RW = 3'b011;
   localparam bit [2:0] MX = 3'b010;
   localparam bit [2:0] WD = 3'b101;
   logic                        core_clk_i;
   logic                        rst_n_i;
   logic [2:0]                  req;
   logic                        req_wr;
   logic [hpbp_pkg::ADDR_W-1:0] req_addr;
   logic [hpbp_pkg::DATA_W-1:0] req_wdata;
   logic [2:0]                  busy, done, reg_wr, reg_rd, reg_wide;
   logic [2:0]                  rw_style, mux_mode, doe;
   logic [hpbp_pkg::ADDR_W-1:0] reg_addr [3];
   logic [hpbp_pkg::ADDR_W-1:0] wa [3];
   logic [hpbp_pkg::DATA_W-1:0] reg_wdata [3];
   logic [hpbp_pkg::DATA_W-1:0] rdata [3];
   logic [hpbp_pkg::DATA_W-1:0] lvl [3];
   logic [hpbp_pkg::DATA_W-1:0] wd [3];
   int                          wcnt [3], rcnt [3], dcnt [3];
   int                          err_total;
   int                          n_checks;

   for (genvar g = 0; g < 3; g++) begin : pr
      hpbp_if bus ();
      // register file answers with the address in the low byte and its inverse in the high byte
      hpbp_dev_end i_hpbp_dev_end (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .bus(bus.dev),
         .reg_addr_o(reg_addr[g]), .reg_wdata_o(reg_wdata[g]), .reg_wr_o(reg_wr[g]),
         .reg_rd_o(reg_rd[g]), .reg_wide_o(reg_wide[g]),
         .reg_rdata_i({~reg_addr[g], reg_addr[g]}), .rw_style_o(rw_style[g]),
         .mux_mode_o(mux_mode[g]));
      hpbp_host_end #(.RW_STYLE(RW[g]), .MUX_MODE(MX[g]), .WIDE(WD[g])) i_hpbp_host_end (
         .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .bus(bus.host), .req_i(req[g]),
         .req_wr_i(req_wr), .req_addr_i(req_addr), .req_wdata_i(req_wdata),
         .busy_o(busy[g]), .done_o(done[g]), .rdata_o(rdata[g]));
      assign doe[g] = bus.dev_doe;
      assign lvl[g] = bus.data_lvl;
      always @(posedge core_clk_i) begin
         if (reg_wr[g] === 1'b1) begin
            wa[g] <= reg_addr[g];
            wd[g] <= reg_wdata[g];
            wcnt[g] <= wcnt[g] + 1;
         end
         if (reg_rd[g] === 1'b1) begin
            rcnt[g] <= rcnt[g] + 1;
         end
         if (done[g] === 1'b1) begin
            dcnt[g] <= dcnt[g] + 1;
         end
      end
      if (g == 0) begin : chk
         hpbp_bus_properties i_hpbp_bus_properties (.core_clk_i(core_clk_i),
            .rst_n_i(rst_n_i), .cs_n(bus.cs_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
            .ale(bus.ale), .addr(bus.addr), .host_doe(bus.host_doe), .dev_doe(bus.dev_doe));
      end
   end

   initial begin
      core_clk_i = 1'b0;
      forever #20 core_clk_i = ~core_clk_i;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up

   // each host drops its request once it shows busy, so it is taken only once
   task automatic run_req(input logic wr, input logic [7:0] a, input logic [15:0] d);
      int n;
      int d0 [3];
      d0 = dcnt;
      @(negedge core_clk_i);
      req_wr = wr;
      req_addr = a;
      req_wdata = d;
      req = 3'b111;
      n = 0;
      while ((dcnt[0] == d0[0] || dcnt[1] == d0[1] || dcnt[2] == d0[2]) && n < 60) begin
         @(negedge core_clk_i);
         req = req & ~busy;
         n++;
      end
      for (int g = 0; g < 3; g++) begin
         `CHK(dcnt[g], d0[g] + 1)
      end
      repeat (5) @(negedge core_clk_i);
      `CHK(busy, 3'b000)
   endtask : run_req

   task automatic t_reset();
      repeat (8) @(negedge core_clk_i);
      `CHK(doe, 3'b000)
      `CHK(lvl[0] & lvl[1] & lvl[2], 16'hffff)
      `CHK(rw_style, 3'b000)
      repeat (8) @(negedge core_clk_i);
      rst_n_i = 1'b1;
      repeat (6) @(negedge core_clk_i);
      `CHK(rw_style, 3'b011)
      `CHK(mux_mode, 3'b000)
      $display("test reset done");
   endtask : t_reset

   task automatic t_write(input int cnt);
      run_req(1'b1, 8'h5a, 16'hbeef);
      for (int g = 0; g < 3; g++) begin
         `CHK(wa[g], 8'h5a)
         `CHK(wcnt[g], cnt)
      end
      `CHK(wd[0], 16'hbeef)
      `CHK(wd[1], 16'h00ef)
      `CHK(wd[2], 16'hbeef)
      `CHK(reg_wide, 3'b101)
      `CHK(mux_mode, 3'b010)
      $display("test write done");
   endtask : t_write

   task automatic t_b2b();
      run_req(1'b1, 8'ha5, 16'h1234);
      run_req(1'b1, 8'h01, 16'h8001);
      for (int g = 0; g < 3; g++) begin
         `CHK(wa[g], 8'h01)
         `CHK(wcnt[g], 3)
      end
      `CHK(wd[1], 16'h0001)
      `CHK(wd[2], 16'h8001)
      $display("test back to back done");
   endtask : t_b2b

   task automatic t_read();
      logic [7:0] adr [3];
      adr = '{8'h3c, 8'hff, 8'h00};
      for (int i = 0; i < 3; i++) begin
         run_req(1'b0, adr[i], 16'h0000);
         `CHK(rdata[0], {~adr[i], adr[i]})
         `CHK(rdata[1], {8'h00, adr[i]})
         `CHK(rdata[2], {~adr[i], adr[i]})
      end
      `CHK(doe, 3'b000)
      `CHK(lvl[0], 16'hffff)
      `CHK(wcnt[0], 3)
      for (int g = 0; g < 3; g++) begin
         `CHK(rcnt[g], 3)
      end
      $display("test read done");
   endtask : t_read

   task automatic t_rerst();
      @(negedge core_clk_i);
      rst_n_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      `CHK(doe, 3'b000)
      `CHK(mux_mode, 3'b000)
      rst_n_i = 1'b1;
      repeat (6) @(negedge core_clk_i);
      `CHK(rw_style, 3'b011)
      t_write(4);
      $display("test second reset done");
   endtask : t_rerst

   initial begin
      rst_n_i = 1'b0;
      req = 3'b000;
      req_wr = 1'b0;
      req_addr = 8'h00;
      req_wdata = 16'h0000;
      t_reset();
      t_write(1);
      t_b2b();
      t_read();
      t_rerst();
      wrap_up();
   end

   // all tests need well under 1000 cycles
   initial begin
      #(40 * 3000);
      err_total++;
      $display("ERROR %0t: watchdog expired", $time);
      wrap_up();
   end
endmodule : tb_host_processor_bus_port
